// File: rtl/asram_pkg.sv
package asram_pkg;

   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_PS = 5000;

   // Timing figures in ps, fast grade
   localparam int T_AA_PS = 15000;
   localparam int T_OHA_PS = 3000;
   localparam int T_HZOE_PS = 7000;
   localparam int T_AW_PS = 10000;
   localparam int T_SA_PS = 0;
   localparam int T_HA_PS = 0;
   localparam int T_SD_PS = 9000;
   localparam int T_HD_PS = 0;
   localparam int T_PWE_PS = 9000;
   localparam int T_WC_PS = 15000;
   localparam int T_RC_PS = 15000;

   function automatic int cyc_min(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_min

   localparam int RD_CYC = cyc_min(T_AA_PS) + 1;
   localparam int HZ_CYC = cyc_min(T_HZOE_PS);
   localparam int WR_CYC = cyc_min(T_AW_PS > T_PWE_PS ? T_AW_PS : T_PWE_PS);
   localparam int SD_CYC = cyc_min(T_SD_PS);
   localparam int HD_CYC = cyc_min(T_HD_PS);
   localparam int GAP_CYC = cyc_min(T_OHA_PS);
   localparam int CNT_W = 4;

   typedef struct packed {
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asram_req_t;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
   } asram_pins_t;

   // Select, gate and strobe idle high; address parked at zero
   localparam asram_pins_t PINS_RST = '{
      ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000
   };

endpackage : asram_pkg

// File: rtl/asram_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module asram_sync2 (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [asram_pkg::DATA_W-1:0] d_i,
   output logic [asram_pkg::DATA_W-1:0] q_o
);
   import asram_pkg::*;
   logic [DATA_W-1:0] meta_q;

   // First stage read only by the second
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         meta_q <= 8'h00;
         q_o <= 8'h00;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : asram_sync2
`default_nettype wire

// File: rtl/asram_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module asram_ctrl (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   input wire asram_pkg::asram_req_t req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [asram_pkg::DATA_W-1:0] rsp_data_o,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [asram_pkg::ADDR_W-1:0] addr_o,
   input wire logic [asram_pkg::DATA_W-1:0] dq_i,
   output logic [asram_pkg::DATA_W-1:0] dq_o,
   output logic dq_oe_o
);
   import asram_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RD, ST_RD_DONE, ST_WR_SETUP, ST_WR, ST_WR_HOLD, ST_GAP
   } asram_state_t;

   asram_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   asram_pins_t pins_q, pins_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic dq_oe_q, dq_oe_d;
   logic rsp_valid_q, rsp_valid_d;
   logic [DATA_W-1:0] rsp_data_q, rsp_data_d;
   logic [DATA_W-1:0] dq_sync;
   logic cnt_done;
   logic take;
   logic in_idle;
   logic wr_take;
   logic rd_take;
   logic next_idle;
   logic [CNT_W-1:0] cnt_dec;

   // Read data comes in from the pins through two flops
   asram_sync2 u_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .d_i(dq_i),
      .q_o(dq_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Take only while ready shows, never on the edge leaving reset
   assign in_idle = (state_q == ST_IDLE);
   assign take = in_idle && req_ready_o && req_valid_i;
   assign wr_take = take && req_i.we;
   assign rd_take = take && !req_i.we;
   assign next_idle = (state_d == ST_IDLE);
   assign cnt_done = (cnt_q == '0);
   assign cnt_dec = cnt_q - 4'h1;

   ////////////////////////////////////////////////////////////////////////
   // Step counts are cut to the counter width on purpose
   function automatic logic [CNT_W-1:0] cnt_load(input int cycles);
      return CNT_W'(cycles);
   endfunction : cnt_load

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      // Counter parks at zero between steps
      cnt_d = cnt_done ? cnt_q : cnt_dec;
      pins_d = pins_q;
      wdata_d = wdata_q;
      dq_oe_d = dq_oe_q;
      rsp_valid_d = 1'b0;
      rsp_data_d = rsp_data_q;
      case (state_q)
         ST_IDLE: begin
            pins_d.ce_n = 1'b1;
            pins_d.oe_n = 1'b1;
            pins_d.we_n = 1'b1;
            if (wr_take) begin
               // Address set before select falls
               pins_d.addr = req_i.addr;
               wdata_d = req_i.wdata;
               state_d = ST_WR_SETUP;
               cnt_d = cnt_load(HZ_CYC);
            end else if (rd_take) begin
               pins_d.addr = req_i.addr;
               pins_d.ce_n = 1'b0;
               pins_d.oe_n = 1'b0;
               state_d = ST_RD;
               cnt_d = cnt_load(RD_CYC + 1);
            end
         end
         ST_RD: begin
            // Strobe stays high through reads
            if (cnt_done) begin
               // Sample through the two-stage synchroniser
               rsp_data_d = dq_sync;
               rsp_valid_d = 1'b1;
               pins_d.oe_n = 1'b1;
               pins_d.ce_n = 1'b1;
               state_d = ST_GAP;
               cnt_d = cnt_load(HZ_CYC);
            end
         end
         ST_WR_SETUP: begin
            // Gate high, bus free from any earlier read
            dq_oe_d = 1'b1;
            if (cnt_done) begin
               pins_d.ce_n = 1'b0;
               pins_d.we_n = 1'b0;
               state_d = ST_WR;
               cnt_d = cnt_load(WR_CYC > SD_CYC ? WR_CYC : SD_CYC);
            end
         end
         ST_WR: begin
            if (cnt_done) begin
               // Both rise together; data held past the edge
               pins_d.we_n = 1'b1;
               pins_d.ce_n = 1'b1;
               state_d = ST_WR_HOLD;
               cnt_d = cnt_load(HD_CYC);
            end
         end
         ST_WR_HOLD: begin
            // Data stays driven past the rising edge
            if (cnt_done) begin
               dq_oe_d = 1'b0;
               state_d = ST_GAP;
               cnt_d = cnt_load(GAP_CYC);
            end
         end
         ST_GAP: begin
            // Recovery time before the next take
            if (cnt_done) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Select, gate and strobe rest high so the memory sleeps in reset
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pins_q <= PINS_RST;
      end else begin
         pins_q <= pins_d;
      end
   end

   // Drive enable falls only after the write has ended
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         wdata_q <= 8'h00;
         dq_oe_q <= 1'b0;
      end else begin
         wdata_q <= wdata_d;
         dq_oe_q <= dq_oe_d;
      end
   end

   // Answer valid stands one cycle, data until the next read
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q <= 8'h00;
      end else begin
         rsp_valid_q <= rsp_valid_d;
         rsp_data_q <= rsp_data_d;
      end
   end

   // Ready follows the next state, so it drops on the taking edge
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         req_ready_o <= 1'b0;
      end else begin
         req_ready_o <= next_idle;
      end
   end

   // Pins and answer shown straight from their flops
   assign ce_n_o = pins_q.ce_n;
   assign oe_n_o = pins_q.oe_n;
   assign we_n_o = pins_q.we_n;
   assign addr_o = pins_q.addr;
   assign dq_o = wdata_q;
   assign dq_oe_o = dq_oe_q;
   assign rsp_valid_o = rsp_valid_q;
   assign rsp_data_o = rsp_data_q;
endmodule : asram_ctrl
`default_nettype wire

// File: test/asram_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module asram_ctrl_asserts (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   input wire asram_pkg::asram_req_t req_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire logic ce_n_o,
   input wire logic oe_n_o,
   input wire logic we_n_o,
   input wire logic [asram_pkg::ADDR_W-1:0] addr_o,
   input wire logic dq_oe_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   AST_WR_SEL: assert property (!we_n_o |-> !ce_n_o)
      else $error("strobe low while deselected");
   AST_WR_GATE: assert property (!we_n_o |-> oe_n_o)
      else $error("gate low during write");
   AST_RD_STRB: assert property (!oe_n_o |-> we_n_o)
      else $error("strobe low during read");
   AST_NO_FIGHT: assert property (dq_oe_o |-> oe_n_o)
      else $error("drive while memory drives");
   AST_WR_DATA: assert property (!we_n_o |-> dq_oe_o)
      else $error("write data not driven");
   AST_WR_LEN: assert property ($rose(we_n_o) |-> !$past(we_n_o, 2))
      else $error("write too short");
   AST_JOINT: assert property ($rose(we_n_o) |-> $rose(ce_n_o))
      else $error("write end not joint");
   AST_ADDR: assert property (!we_n_o |=> $stable(addr_o))
      else $error("address moved in write");
   AST_IDLE: assert property (req_ready_o |-> ce_n_o && !dq_oe_o)
      else $error("idle but selected");
   AST_RD_LAT: assert property (req_valid_i && req_ready_o && !req_i.we
      |-> ##7 rsp_valid_o)
      else $error("read answer late");
   AST_COV_WR: cover property ($rose(we_n_o));
   AST_COV_RD: cover property (rsp_valid_o);
   AST_COV_DRV: cover property ($rose(dq_oe_o));
endmodule : asram_ctrl_asserts
bind asram_ctrl asram_ctrl_asserts chk (.*);
`default_nettype wire

// File: test/asram_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module asram_mem_model #(
   parameter int ACC = 15
) (
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [14:0] addr_i,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o
);
   logic [7:0] mem [32768];
   wire en = !ce_n_i && !oe_n_i && we_n_i;
   // Released lines show inverted data, never a stale match
   assign #ACC dq_o = en ? mem[addr_i] : ~mem[addr_i];
   always @(posedge (ce_n_i | we_n_i)) mem[addr_i] <= dq_i;
endmodule : asram_mem_model
`default_nettype wire

// File: test/async_sram_32kx8_tb.sv
`timescale 1ns/100ps
`default_nettype none
module async_sram_32kx8_tb;
   import asram_pkg::*;
   logic clock_i = 0, reset_i = 1, req_valid_i = 0;
   asram_req_t req_i = '0;
   logic req_ready_o, rsp_valid_o, ce_n_o, oe_n_o, we_n_o, dq_oe_o;
   logic [7:0] rsp_data_o, dq_o, mem_q;
   logic [14:0] addr_o;
   wire [7:0] dq_w = dq_oe_o ? dq_o : mem_q;
   int failures = 0, tests_run = 0;
   always #2.5 clock_i = ~clock_i;
   asram_ctrl dut (.*, .dq_i(dq_w));
   asram_mem_model mem (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
      .we_n_i(we_n_o), .addr_i(addr_o), .dq_i(dq_w), .dq_o(mem_q));
   task report_and_stop;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task tick(inout int n);
      @(negedge clock_i);
      if (++n > 50) begin
         failures++;
         report_and_stop();
      end
   endtask : tick
   // An edge passes first, so valid never falls and rises at once
   task access(input logic w, input logic [14:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge clock_i);
      req_i = '{w, a, d};
      req_valid_i = 1;
      while (req_ready_o !== 1'b1) tick(n);
      @(negedge clock_i);
      req_valid_i = 0;
   endtask : access
   task rd(input logic [14:0] a, input logic [7:0] e);
      int n;
      n = 0;
      access(0, a, 8'h00);
      while (rsp_valid_o !== 1'b1) tick(n);
      // Raised on the sixth rising edge after the take
      chk("latency", 8'h06, 8'(n));
      chk("rdata", e, rsp_data_o);
   endtask : rd
   task t_bits;
      for (int i = 0; i < 15; i++) access(1, 15'(1 << i), 8'(8'h10 + i));
      access(1, 15'h0000, 8'ha5);
      access(1, 15'h7fff, 8'h5a);
      for (int i = 0; i < 15; i++) rd(15'(1 << i), 8'(8'h10 + i));
      rd(15'h7fff, 8'h5a);
      rd(15'h0000, 8'ha5);
   endtask : t_bits
   task t_over;
      access(1, 15'h1234, 8'h3c);
      access(1, 15'h1234, 8'hc3);
      rd(15'h1234, 8'hc3);
      rd(15'h1234, 8'hc3);
   endtask : t_over
   task t_idle;
      int n;
      n = 0;
      while (req_ready_o !== 1'b1) tick(n);
      chk("ce_n", 8'h01, {7'h00, ce_n_o});
      chk("we_n", 8'h01, {7'h00, we_n_o});
      chk("dq_oe", 8'h00, {7'h00, dq_oe_o});
   endtask : t_idle
   initial begin
      repeat (10) @(negedge clock_i);
      reset_i = 0;
      t_bits();
      t_over();
      t_idle();
      report_and_stop();
   end
endmodule : async_sram_32kx8_tb
`default_nettype wire
